//--- rtl/mrseq_top.sv
// Purpose : reset sequencing for a small 8-bit core
// Assumes : CLK_SYS_I is the oscillator; RST_N_I is the power-on detector
// Notes   : pin is split into input, output and enable
`timescale 1ns/1ps
`include "mrseq_consts.svh"
module mrseq_top
   import mrseq_pkg::*;
(
   input  wire logic        CLK_SYS_I,
   input  wire logic        RST_N_I,
   input  wire logic        RESET_PIN_I,
   output logic             RESET_PIN_O,
   output logic             RESET_PIN_OE_O,
   input  wire logic        WDOG_END_I,
   input  wire logic        STOP_MODE_I,
   input  wire logic [7:0]  PMEM_DATA_I,
   input  wire logic        RETURN_FROM_INTERRUPT_INSTRUCTION_I,
   input  wire logic        IRQ_PENDING_I,
   output logic [11:0]      PMEM_ADDR_O,
   output logic             PMEM_RD_O,
   output logic             CORE_RST_N_O,
   output logic             PERIPH_RST_N_O,
   output logic             OSC_RUN_O,
   output logic [11:0]      PC_LOAD_O,
   output logic             PC_LOAD_VALID_O,
   output logic             STACK_CLR_O,
   output logic             NMI_MODE_O,
   output logic             SERVE_IRQ_O,
   output logic             IO_HIZ_O,
   output logic             IO_PULLUP_O,
   output logic             IO_IRQ_EN_O,
   output logic             KEEP_REGS_O,
   output logic [6:0]       PRESC_INIT_O,
   output logic [7:0]       TIMER_COUNT_REGISTER_INIT_O,
   output logic [7:0]       WATCHDOG_COUNT_REGISTER_INIT_O,
   output logic [7:0]       WDOG_REG_ADDR_O
);
   mrseq_state_t state_ff;
   mrseq_state_t nxt_state;
   mrseq_mode_t  mode_ff;
   logic [11:0]  cnt_ff;
   logic [7:0]   vec_lo_ff;
   logic         pin_sync;
   logic         wdog_pull_ff;
   logic         stopped_ff;

   // ---------------------------------------------------------------
   // pin sampling
   // ---------------------------------------------------------------
   // pin is asynchronous; sync before the counter sees it
   mrseq_sync u_pin_sync
   (
      .clk_i     (CLK_SYS_I),
      .rst_n_i   (RST_N_I),
      .d_i       (RESET_PIN_I),
      .q_o       (pin_sync)
   );

   // ---------------------------------------------------------------
   // watchdog pull-down
   // ---------------------------------------------------------------
   // pull low on end of count, release once reset state is entered
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         wdog_pull_ff <= 1'b0;
      else if (state_ff == ST_HOLD)
         wdog_pull_ff <= 1'b0;
      else if (WDOG_END_I)
         wdog_pull_ff <= 1'b1;
   end
   // open drain: only ever drives low
   assign RESET_PIN_O    = 1'b0;
   assign RESET_PIN_OE_O = wdog_pull_ff;

   // remember stop mode to report oscillator restart
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         stopped_ff <= 1'b0;
      else if (state_ff == ST_RUN)
         stopped_ff <= STOP_MODE_I;
   end

   // ---------------------------------------------------------------
   // sequence state machine
   // ---------------------------------------------------------------
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_HOLD:   if (pin_sync) nxt_state = ST_STAB;
         ST_STAB:   if (!pin_sync) nxt_state = ST_HOLD;
                    else if (cnt_ff == `MRSEQ_STAB_LAST) nxt_state = ST_VEC_LO;
         ST_VEC_LO: nxt_state = ST_VEC_HI;
         ST_VEC_HI: nxt_state = ST_RUN;
         ST_RUN:    nxt_state = ST_RUN;
         default:   nxt_state = ST_HOLD;
      endcase
      // any low level seen on the pin restarts the sequence
      if (!pin_sync)
         nxt_state = ST_HOLD;
   end

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         state_ff <= ST_HOLD;
      else
         state_ff <= nxt_state;
   end

   // stabilisation counter, cleared whenever not counting
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         cnt_ff <= 12'h000;
      else if (state_ff == ST_STAB && pin_sync)
         cnt_ff <= cnt_ff + 12'h001;
      else
         cnt_ff <= 12'h000;
   end

   // ---------------------------------------------------------------
   // vector fetch
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         vec_lo_ff       <= 8'h00;
         PC_LOAD_O       <= 12'h000;
         PC_LOAD_VALID_O <= 1'b0;
      end
      else
      begin
         PC_LOAD_VALID_O <= 1'b0;
         if (state_ff == ST_VEC_LO)
            vec_lo_ff <= PMEM_DATA_I;
         if (state_ff == ST_VEC_HI)
         begin
            PC_LOAD_O       <= {PMEM_DATA_I[3:0], vec_lo_ff};
            PC_LOAD_VALID_O <= 1'b1;
         end
      end
   end
   // memory is assumed to return data in the same cycle
   assign PMEM_RD_O   = (state_ff == ST_VEC_LO) || (state_ff == ST_VEC_HI);
   assign PMEM_ADDR_O = (state_ff == ST_VEC_HI) ? `MRSEQ_RST_VEC_HI : `MRSEQ_RST_VEC_LO;

   // ---------------------------------------------------------------
   // interrupt mode
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         mode_ff <= MD_NMI;
      else if (state_ff != ST_RUN)
         mode_ff <= MD_NMI;
      else if (RETURN_FROM_INTERRUPT_INSTRUCTION_I)
         mode_ff <= MD_NORMAL;
   end
   assign NMI_MODE_O  = (mode_ff == MD_NMI);
   // first return: pending request served, else fall through
   assign SERVE_IRQ_O = (state_ff == ST_RUN) && (mode_ff == MD_NMI)
                        && RETURN_FROM_INTERRUPT_INSTRUCTION_I && IRQ_PENDING_I;

   // ---------------------------------------------------------------
   // reset outputs and presets
   // ---------------------------------------------------------------
   // core released synchronously, only after the vector is loaded
   assign CORE_RST_N_O   = (state_ff == ST_RUN);
   assign PERIPH_RST_N_O = (state_ff != ST_HOLD) && (state_ff != ST_STAB);
   assign STACK_CLR_O    = (state_ff != ST_RUN);
   assign IO_HIZ_O       = (state_ff != ST_RUN);
   assign IO_PULLUP_O    = (state_ff != ST_RUN);
   assign IO_IRQ_EN_O    = 1'b0;
   assign KEEP_REGS_O    = 1'b1;
   // oscillator restarted at any reset, including from stop
   assign OSC_RUN_O      = (state_ff != ST_RUN) || !stopped_ff || !STOP_MODE_I;
   assign PRESC_INIT_O                   = `MRSEQ_PRESC_RST;
   assign TIMER_COUNT_REGISTER_INIT_O    = `MRSEQ_TCOUNT_RST;
   assign WATCHDOG_COUNT_REGISTER_INIT_O = `MRSEQ_WDOG_RST;
   assign WDOG_REG_ADDR_O                = `MRSEQ_WDOG_ADDR;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_pin_high_long;
      pin_sync [*8];
   endsequence

   AST_LOW_HOLDS: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      !pin_sync |=> !CORE_RST_N_O) else $error("core left reset with pin low");
   AST_NO_EARLY: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      $rose(pin_sync) |-> !CORE_RST_N_O [*8]) else $error("early release");
   AST_WDOG_PULL: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (WDOG_END_I && state_ff == ST_RUN) |=> RESET_PIN_OE_O) else $error("no pull");
   AST_WDOG_FREE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (state_ff == ST_HOLD) |=> !RESET_PIN_OE_O) else $error("pull not freed");
   AST_VEC_ADDR: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (state_ff == ST_VEC_LO && pin_sync) |-> PMEM_ADDR_O == 12'hFFE ##1 PMEM_ADDR_O == 12'hFFF)
      else $error("bad vector address");
   AST_NMI_START: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      $rose(CORE_RST_N_O) |-> NMI_MODE_O) else $error("not nmi mode");
   AST_IO_RESET: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      !CORE_RST_N_O |-> IO_PULLUP_O && IO_HIZ_O && !IO_IRQ_EN_O)
      else $error("io not in reset config");
   AST_RELEASE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (state_ff == ST_STAB && cnt_ff == `MRSEQ_STAB_LAST && pin_sync)
      |-> ##3 CORE_RST_N_O) else $error("release late");
   AST_SERVE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      SERVE_IRQ_O |=> !NMI_MODE_O) else $error("mode kept");
   AST_STAB_RUN: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (state_ff == ST_STAB) and s_pin_high_long |-> !CORE_RST_N_O)
      else $error("run during stabilisation");
endmodule : mrseq_top

//--- inc/mrseq_consts.svh
// Purpose : constants for the reset sequencer
// Assumes : included by rtl files only
// Notes   : offsets are data space addresses
`ifndef MRSEQ_CONSTS_SVH
`define MRSEQ_CONSTS_SVH
`define MRSEQ_STAB_CYCLES     12'h800
`define MRSEQ_STAB_LAST       12'h7FF
`define MRSEQ_RST_VEC_LO      12'hFFE
`define MRSEQ_RST_VEC_HI      12'hFFF
`define MRSEQ_DATA_WIN_ADDR   8'hC9
`define MRSEQ_PROG_PAGE_ADDR  8'hCA
`define MRSEQ_RAM_BANK_ADDR   8'hCB
`define MRSEQ_WDOG_ADDR       8'hD8
`define MRSEQ_PRESC_RST       7'h7F
`define MRSEQ_TCOUNT_RST      8'hFF
`define MRSEQ_WDOG_RST        8'hFE
`endif

//--- inc/mrseq_pkg.sv
// Purpose : types for the reset sequencer
// Assumes : nothing
// Notes   : none
package mrseq_pkg;
   typedef enum logic [2:0] {ST_HOLD, ST_STAB, ST_VEC_LO, ST_VEC_HI, ST_RUN} mrseq_state_t;
   typedef enum logic [1:0] {MD_NMI, MD_NORMAL} mrseq_mode_t;
endpackage : mrseq_pkg

//--- rtl/mrseq_sync.sv
// Purpose : two flop synchroniser for one level
// Assumes : asynchronous input
// Notes   : first flop read only by the second
`timescale 1ns/1ps
module mrseq_sync
(
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic d_i,
   output logic      q_o
);
   logic meta_ff;
   // ---------------------------------------------------------------
   // double flop
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta_ff <= 1'b0;
         q_o     <= 1'b0;
      end
      else
      begin
         meta_ff <= d_i;
         q_o     <= meta_ff;
      end
   end
endmodule : mrseq_sync

//--- sim/mrseq_pin_src.sv
// Purpose : reset pin wire with an external supervisor on it
// Assumes : pin has an internal pull-up
// Notes   : open drain; any party pulling low wins
`timescale 1ns/1ps
module mrseq_pin_src
(
   input  wire logic ext_low_i,
   input  wire logic dev_oe_i,
   input  wire logic dev_o_i,
   output logic      pin_o
);
   // ----------------
   // wired-and pin
   // ----------------
   // released pin goes to the pull-up level, never holds the last value
   assign pin_o = (ext_low_i | (dev_oe_i & ~dev_o_i)) ? 1'b0 : 1'b1;
endmodule : mrseq_pin_src

//--- sim/tb_top.sv
// Purpose : self-checking bench for the reset sequencer
// Assumes : vector held at FFE/FFF is 34h/A5h
// Notes   : release window allows sync and fetch cycles
`timescale 1ns/1ps
`define CHK(a,b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
 $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end
module tb_top;
   import mrseq_pkg::*;
   logic clk = 0, rst_n = 0, ext_low = 0, wdog = 0, stop = 0, return_from_interrupt_instruction = 0, irq = 0;
   logic [7:0] pdat;
   logic [11:0] paddr, pc;
   logic pin, po, poe, prd, crst, prst, osc, pcv, sclr, nmi, srv, hiz, pup, ien, keep;
   logic [6:0] presc;
   logic [7:0] timer_count_register, wcr, wadr;
   int bad_count = 0, checks_done = 0, cyc = 0;
   always #25 clk = ~clk;
   // program memory answers in the address cycle
   always_comb pdat = (paddr == 12'hFFE) ? 8'h34 : (paddr == 12'hFFF) ? 8'hA5 : 8'h00;
   mrseq_pin_src PIN (.ext_low_i(ext_low), .dev_oe_i(poe), .dev_o_i(po), .pin_o(pin));
   mrseq_top DUT (.CLK_SYS_I(clk), .RST_N_I(rst_n), .RESET_PIN_I(pin), .RESET_PIN_O(po),
      .RESET_PIN_OE_O(poe), .WDOG_END_I(wdog), .STOP_MODE_I(stop), .PMEM_DATA_I(pdat),
      .RETURN_FROM_INTERRUPT_INSTRUCTION_I(return_from_interrupt_instruction), .IRQ_PENDING_I(irq), .PMEM_ADDR_O(paddr),
      .PMEM_RD_O(prd), .CORE_RST_N_O(crst), .PERIPH_RST_N_O(prst), .OSC_RUN_O(osc),
      .PC_LOAD_O(pc), .PC_LOAD_VALID_O(pcv), .STACK_CLR_O(sclr), .NMI_MODE_O(nmi),
      .SERVE_IRQ_O(srv), .IO_HIZ_O(hiz), .IO_PULLUP_O(pup), .IO_IRQ_EN_O(ien),
      .KEEP_REGS_O(keep), .PRESC_INIT_O(presc), .TIMER_COUNT_REGISTER_INIT_O(timer_count_register),
      .WATCHDOG_COUNT_REGISTER_INIT_O(wcr), .WDOG_REG_ADDR_O(wadr));
   // ----------------
   // shared tasks
   // ----------------
   task finish_test;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test
   // hang guard: whole run is about 11k cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         bad_count++;
         finish_test();
      end
   end
   // reset state seen on outputs
   task chk_held;
      `CHK(crst, 1'b0)
      `CHK(hiz, 1'b1)
      `CHK(pup, 1'b1)
      `CHK(ien, 1'b0)
      `CHK(sclr, 1'b1)
      `CHK(prst, 1'b0)
   endtask : chk_held
   // wait for core release, counting cycles from the task call
   task wait_rel;
      int n;
      bit lo, hi;
      n = 0; lo = 0; hi = 0;
      while (crst !== 1'b1 && n < 3000)
      begin
         @(negedge clk);
         n++;
         lo |= (prd === 1'b1 && paddr === 12'hFFE);
         hi |= (prd === 1'b1 && paddr === 12'hFFF);
      end
      `CHK(n >= 2048 && n <= 2058, 1'b1)
      `CHK(lo && hi, 1'b1)
      `CHK(pc, 12'h534)
      `CHK(pcv, 1'b1)
      `CHK(nmi, 1'b1)
      `CHK(hiz, 1'b0)
   endtask : wait_rel
   task pin_low(input int n);
      ext_low = 1;
      repeat (n) @(negedge clk);
      ext_low = 0;
   endtask : pin_low
   task wait_hold;
      repeat (4) @(negedge clk);
      chk_held();
   endtask : wait_hold
   // ----------------
   // scenarios
   // ----------------
   task t_por;
      chk_held();
      `CHK(nmi, 1'b1)
      `CHK({presc, timer_count_register, wcr, wadr}, {7'h7F, 8'hFF, 8'hFE, 8'hD8})
      `CHK(keep, 1'b1)
      rst_n = 1;
      wait_rel();
      $display("test por done");
   endtask : t_por
   task t_short;
      pin_low(1);
      wait_hold();
      wait_rel();
      $display("test short pulse done");
   endtask : t_short
   task t_abort;
      pin_low(1);
      repeat (1000) @(negedge clk);
      pin_low(2); // restart in mid count
      wait_hold();
      wait_rel();
      $display("test abort done");
   endtask : t_abort
   task t_wdog;
      wdog = 1;
      @(negedge clk);
      wdog = 0;
      `CHK({poe, po}, 2'b10)
      repeat (3) @(negedge clk);
      chk_held();
      @(negedge clk);
      `CHK(poe, 1'b0)
      wait_rel();
      $display("test watchdog done");
   endtask : t_wdog
   task t_stop;
      stop = 1;
      @(negedge clk);
      `CHK(osc, 1'b0)
      pin_low(10);
      stop = 0;
      `CHK(osc, 1'b1)
      `CHK(hiz, 1'b1)
      wait_rel();
      // first return with nothing pending just leaves nmi mode
      return_from_interrupt_instruction = 1;
      #1;
      `CHK(srv, 1'b0)
      @(negedge clk);
      return_from_interrupt_instruction = 0;
      `CHK(nmi, 1'b0)
      $display("test stop done");
   endtask : t_stop
   task t_return_from_interrupt_instruction;
      irq = 1;
      return_from_interrupt_instruction = 1;
      #1;
      `CHK(srv, 1'b1)
      @(negedge clk);
      return_from_interrupt_instruction = 0;
      `CHK(nmi, 1'b0)
      @(negedge clk);
      return_from_interrupt_instruction = 1;
      #1;
      `CHK(srv, 1'b0)
      @(negedge clk);
      return_from_interrupt_instruction = 0;
      irq = 0;
      $display("test return done");
   endtask : t_return_from_interrupt_instruction
   initial
   begin
      repeat (20) @(negedge clk);
      t_por();
      t_return_from_interrupt_instruction();
      t_short();
      t_abort();
      t_wdog();
      t_stop();
      finish_test();
   end
endmodule : tb_top
